// ==== shared/plqc_params.svh ====
`ifndef PLQC_PARAMS_SVH
`define PLQC_PARAMS_SVH

// ==========================================================================
// Timing
`define PLQC_CLK_PERIOD_NS 4
`define PLQC_TX_SETTLE_NS 500
`define PLQC_TX_SETTLE_CYC (`PLQC_TX_SETTLE_NS / `PLQC_CLK_PERIOD_NS)
`define PLQC_SLEEP_NS 2000
`define PLQC_SLEEP_CYC \
	((`PLQC_SLEEP_NS + `PLQC_CLK_PERIOD_NS - 1) / `PLQC_CLK_PERIOD_NS)
`define PLQC_QUIET_NS 16000
`define PLQC_QUIET_CYC \
	((`PLQC_QUIET_NS + `PLQC_CLK_PERIOD_NS - 1) / `PLQC_CLK_PERIOD_NS)
`define PLQC_REFRESH_NS 1000
`define PLQC_REFRESH_CYC \
	((`PLQC_REFRESH_NS + `PLQC_CLK_PERIOD_NS - 1) / `PLQC_CLK_PERIOD_NS)
`define PLQC_WAKE_NS 500
`define PLQC_WAKE_CYC \
	((`PLQC_WAKE_NS + `PLQC_CLK_PERIOD_NS - 1) / `PLQC_CLK_PERIOD_NS)

// ==========================================================================
// Widths and reset values
`define PLQC_LANES 4
`define PLQC_CNT_W 12
`define PLQC_LANE_EN_RST 4'hF
`define PLQC_STATUS_RST 4'h2

`endif

// ==== shared/plqc_pkg.sv ====
`default_nettype none
package plqc_pkg;

	// Quiet requests from the PCS processes.
	typedef struct packed {
		logic tx_quiet;
		logic rx_quiet;
	} plqc_quiet_req_s;

	// Transmit side LPI sequence.
	typedef enum logic [2:0] {
		PLQC_ACTIVE = 3'h0,
		PLQC_SLEEP = 3'h1,
		PLQC_QUIET = 3'h2,
		PLQC_REFRESH = 3'h3,
		PLQC_WAKE = 3'h4
	} plqc_state_e;

	// Status flags toward the client and the analog front end.
	typedef struct packed {
		logic tx_lpi_code;
		logic client_lpi_ind;
		logic tx_func_active;
		logic refresh_burst;
	} plqc_status_s;

endpackage
`default_nettype wire

// ==== hw/plqc_lane_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "plqc_params.svh"

module plqc_lane_gate (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Requests
	input wire logic eee_supported,
	input wire plqc_pkg::plqc_quiet_req_s quiet_req,
	// Gated controls
	output logic [`PLQC_LANES-1:0] tx_lane_en,
	output logic rx_low_power
);

	// ======================================================================
	// Qualified requests
	wire tx_quiet_eff = eee_supported & quiet_req.tx_quiet;
	wire rx_quiet_eff = eee_supported & quiet_req.rx_quiet;

	logic tx_quiet_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tx_quiet_q <= 1'b0;
			tx_lane_en <= `PLQC_LANE_EN_RST;
			rx_low_power <= 1'b0;
		end
		else
		begin
			tx_quiet_q <= tx_quiet_eff;
			tx_lane_en <= {`PLQC_LANES{~tx_quiet_q}};
			rx_low_power <= rx_quiet_eff;
		end
	end

	// ======================================================================
	// Checks
	chk_rx_low_follow: assert property (
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> rx_low_power == $past(rx_quiet_eff))
		else $error("Receiver low power does not follow rx_quiet.");
	chk_no_eee_rx: assert property (
		@(posedge sys_clk) disable iff (rst)
		!eee_supported |=> !rx_low_power)
		else $error("Receiver idled without energy support.");
	chk_lane_two_cyc: assert property (
		@(posedge sys_clk) disable iff (rst)
		tx_quiet_eff ##1 tx_quiet_eff |=> tx_lane_en == 4'h0)
		else $error("Lanes not disabled two cycles after quiet.");

endmodule
`default_nettype wire

// ==== hw/plqc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "plqc_params.svh"

module plqc_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Energy-efficient operation supported
	input wire logic eee_supported,
	// Quiet requests from the PCS
	input wire plqc_pkg::plqc_quiet_req_s quiet_req,
	// Client and receive symbol indications
	input wire logic client_lpi_assert,
	input wire logic rx_lpi_code_seen,
	// Lane and receiver controls
	output logic [`PLQC_LANES-1:0] tx_lane_en,
	output logic rx_low_power,
	// LPI sequence status
	output plqc_pkg::plqc_status_s lpi_status,
	output plqc_pkg::plqc_state_e lpi_state
);

	localparam int TX_SETTLE_MAX = `PLQC_TX_SETTLE_CYC;
	localparam logic [`PLQC_CNT_W-1:0] SLEEP_LD =
		`PLQC_CNT_W'(`PLQC_SLEEP_CYC - 1);
	localparam logic [`PLQC_CNT_W-1:0] QUIET_LD =
		`PLQC_CNT_W'(`PLQC_QUIET_CYC - 1);
	localparam logic [`PLQC_CNT_W-1:0] REFRESH_LD =
		`PLQC_CNT_W'(`PLQC_REFRESH_CYC - 1);
	localparam logic [`PLQC_CNT_W-1:0] WAKE_LD =
		`PLQC_CNT_W'(`PLQC_WAKE_CYC - 1);

	// ======================================================================
	// Lane gating and receiver power
	plqc_lane_gate u_gate (
		.sys_clk(sys_clk),
		.rst(rst),
		.eee_supported(eee_supported),
		.quiet_req(quiet_req),
		.tx_lane_en(tx_lane_en),
		.rx_low_power(rx_low_power)
	);

	// ======================================================================
	// Helpers

	// Phases in which the transmitter has stopped sending normal symbols.
	function automatic logic is_lpi_idle(input plqc_pkg::plqc_state_e s);
		is_lpi_idle = (s == plqc_pkg::PLQC_QUIET) ||
			(s == plqc_pkg::PLQC_REFRESH);
	endfunction

	// ======================================================================
	// Transmit LPI sequence
	plqc_pkg::plqc_state_e state_q;
	plqc_pkg::plqc_state_e state_d;
	logic [`PLQC_CNT_W-1:0] cnt_q;
	logic [`PLQC_CNT_W-1:0] cnt_d;
	plqc_pkg::plqc_status_s status_d;

	wire lpi_eff = eee_supported & client_lpi_assert;
	wire cnt_done = (cnt_q == `PLQC_CNT_W'h0);
	wire [`PLQC_CNT_W-1:0] cnt_dec = cnt_q - `PLQC_CNT_W'h1;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_done ? cnt_q : cnt_dec;
		case (state_q)
			plqc_pkg::PLQC_ACTIVE:
			begin
				if (lpi_eff)
				begin
					state_d = plqc_pkg::PLQC_SLEEP;
					cnt_d = SLEEP_LD;
				end
			end
			plqc_pkg::PLQC_SLEEP:
			begin
				if (!lpi_eff)
					state_d = plqc_pkg::PLQC_ACTIVE;
				else if (cnt_done)
				begin
					state_d = plqc_pkg::PLQC_QUIET;
					cnt_d = QUIET_LD;
				end
			end
			plqc_pkg::PLQC_QUIET:
			begin
				if (!lpi_eff)
				begin
					state_d = plqc_pkg::PLQC_WAKE;
					cnt_d = WAKE_LD;
				end
				else if (cnt_done)
				begin
					state_d = plqc_pkg::PLQC_REFRESH;
					cnt_d = REFRESH_LD;
				end
			end
			plqc_pkg::PLQC_REFRESH:
			begin
				if (!lpi_eff)
				begin
					state_d = plqc_pkg::PLQC_WAKE;
					cnt_d = WAKE_LD;
				end
				else if (cnt_done)
				begin
					state_d = plqc_pkg::PLQC_QUIET;
					cnt_d = QUIET_LD;
				end
			end
			plqc_pkg::PLQC_WAKE:
			begin
				if (cnt_done)
					state_d = plqc_pkg::PLQC_ACTIVE;
			end
			default:
			begin
				state_d = plqc_pkg::PLQC_ACTIVE;
				cnt_d = `PLQC_CNT_W'h0;
			end
		endcase
	end

	// tx_func_active and refresh_burst follow the next state, the other two flags follow the inputs; each flag leaves a flip-flop.
	always_comb
	begin
		status_d.tx_lpi_code = lpi_eff;
		status_d.client_lpi_ind = eee_supported & rx_lpi_code_seen;
		status_d.tx_func_active = (state_d != plqc_pkg::PLQC_QUIET);
		status_d.refresh_burst = (state_d == plqc_pkg::PLQC_REFRESH);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q <= plqc_pkg::PLQC_ACTIVE;
			cnt_q <= `PLQC_CNT_W'h0;
			lpi_status <= `PLQC_STATUS_RST;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			lpi_status <= status_d;
		end
	end

	assign lpi_state = state_q;

	// ======================================================================
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence seq_enter_sleep;
		state_q == plqc_pkg::PLQC_ACTIVE && lpi_eff;
	endsequence

	sequence seq_sleep_done;
		state_q == plqc_pkg::PLQC_SLEEP && cnt_done && lpi_eff;
	endsequence

	sequence seq_resume;
		is_lpi_idle(state_q) && !lpi_eff;
	endsequence

	sequence seq_refresh_done;
		state_q == plqc_pkg::PLQC_REFRESH && cnt_done && lpi_eff;
	endsequence

	chk_tx_quiet_time: assert property (
		(eee_supported && quiet_req.tx_quiet)[*3] |->
		##[0:TX_SETTLE_MAX] tx_lane_en == 4'h0)
		else $error("Lanes not quiet in time.");
	chk_tx_wake_time: assert property (
		(!eee_supported || !quiet_req.tx_quiet)[*3] |->
		##[0:TX_SETTLE_MAX] tx_lane_en == 4'hF)
		else $error("Lanes not restored in time.");
	chk_no_eee_tx: assert property (
		(!eee_supported)[*3] |-> tx_lane_en == 4'hF)
		else $error("Lanes disabled without energy support.");
	chk_sleep_entry: assert property (
		seq_enter_sleep |=> state_q == plqc_pkg::PLQC_SLEEP &&
		cnt_q == SLEEP_LD)
		else $error("Sleep period not started.");
	chk_quiet_entry: assert property (
		seq_sleep_done |=> state_q == plqc_pkg::PLQC_QUIET &&
		!lpi_status.tx_func_active)
		else $error("Transmit functions not stopped after sleep.");
	chk_sleep_abort: assert property (
		state_q == plqc_pkg::PLQC_SLEEP && !lpi_eff |=>
		state_q == plqc_pkg::PLQC_ACTIVE)
		else $error("Sleep not abandoned on normal idle.");
	chk_refresh_due: assert property (
		state_q == plqc_pkg::PLQC_QUIET && cnt_done && lpi_eff |=>
		lpi_status.refresh_burst && cnt_q == REFRESH_LD)
		else $error("Refresh burst missed.");
	chk_refresh_end: assert property (
		seq_refresh_done |=> state_q == plqc_pkg::PLQC_QUIET &&
		cnt_q == QUIET_LD && !lpi_status.refresh_burst)
		else $error("Refresh burst not ended.");
	chk_resume_wake: assert property (
		seq_resume |=> state_q == plqc_pkg::PLQC_WAKE &&
		lpi_status.tx_func_active)
		else $error("Transmit not reactivated on idle.");
	chk_wake_length: assert property (
		state_q == plqc_pkg::PLQC_WAKE && !cnt_done |=>
		state_q == plqc_pkg::PLQC_WAKE)
		else $error("Wake period cut short.");
	chk_lpi_coding: assert property (
		lpi_eff |=> lpi_status.tx_lpi_code)
		else $error("LPI request not coded.");
	chk_lpi_report: assert property (
		$rose(eee_supported && rx_lpi_code_seen) |=>
		lpi_status.client_lpi_ind)
		else $error("Received LPI not reported.");

endmodule
`default_nettype wire

// ==== verif/plqc_pcs_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module plqc_pcs_model (
	// Wanted levels from the bench
	input wire logic tx_want,
	input wire logic rx_want,
	input wire logic lpi_want,
	input wire logic code_want,
	// Toward the block
	output plqc_pkg::plqc_quiet_req_s quiet_req,
	output logic client_lpi_assert,
	output logic rx_lpi_code_seen
);
	// ==========================================================
	// Requests
	// Requests are always TRUE or FALSE levels, never left floating.
	assign quiet_req = '{tx_quiet: tx_want, rx_quiet: rx_want};
	assign client_lpi_assert = lpi_want;
	assign rx_lpi_code_seen = code_want;
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "plqc_params.svh"

module tb_top;
	// ==========================================================
	// Signals
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic eee = 1'b0;
	logic tw = 1'b0;
	logic rw = 1'b0;
	logic lw = 1'b0;
	logic cw = 1'b0;
	logic p1 = 1'b0;
	logic p2 = 1'b0;
	logic r1 = 1'b0;
	logic c1 = 1'b0;
	logic [31:0] seed = 32'h7672;
	plqc_pkg::plqc_quiet_req_s qr;
	logic cla;
	logic rlc;
	logic [`PLQC_LANES-1:0] lane_en;
	logic rx_lp;
	plqc_pkg::plqc_status_s st;
	plqc_pkg::plqc_state_e state;
	int bad_count = 0;
	int checked = 0;

	always #2 sys_clk = ~sys_clk;

	plqc_pcs_model plqc_pcs_model_i (.tx_want(tw), .rx_want(rw),
		.lpi_want(lw), .code_want(cw), .quiet_req(qr),
		.client_lpi_assert(cla), .rx_lpi_code_seen(rlc));

	plqc_top plqc_top_i (.sys_clk(sys_clk), .rst(rst),
		.eee_supported(eee), .quiet_req(qr),
		.client_lpi_assert(cla), .rx_lpi_code_seen(rlc),
		.tx_lane_en(lane_en), .rx_low_power(rx_lp),
		.lpi_status(st), .lpi_state(state));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [3:0] lanes_exp(input logic q);
		return q ? 4'h0 : `PLQC_LANE_EN_RST;
	endfunction

	task automatic chk_v(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_s(input plqc_pkg::plqc_state_e got,
		input plqc_pkg::plqc_state_e exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: state %0d want %0d", $time, got,
				exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task final_report;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		step(6);
		chk_v(lane_en, 4'hF);
		chk_v(st, 4'h2);
		rst = 1'b0;
		tw = 1'b1;
		rw = 1'b1;
		lw = 1'b1;
		cw = 1'b1;
		step(3);
		chk_v(lane_en, 4'hF);
		chk_v({3'h0, rx_lp}, 4'h0);
		chk_s(state, plqc_pkg::PLQC_ACTIVE);
		chk_v(st, 4'h2);
		lw = 1'b0;
		repeat (400)
		begin
			seed = xs(seed);
			chk_v(lane_en, lanes_exp(p2));
			chk_v({st[3:2], rx_lp, st[1]}, {1'b0, c1, r1, 1'b1});
			eee = seed[0] | seed[1];
			tw = seed[2];
			rw = seed[3];
			cw = seed[4];
			p2 = p1;
			p1 = eee & tw;
			r1 = eee & rw;
			c1 = eee & cw;
			step(1);
		end
		eee = 1'b1;
		tw = 1'b0;
		rw = 1'b0;
		cw = 1'b0;
		step(3);
		lw = 1'b1;
		step(1);
		chk_s(state, plqc_pkg::PLQC_SLEEP);
		chk_v(st, 4'hA);
		lw = 1'b0;
		step(1);
		chk_s(state, plqc_pkg::PLQC_ACTIVE);
		step(2);
		lw = 1'b1;
		step(500);
		chk_s(state, plqc_pkg::PLQC_SLEEP);
		step(1);
		chk_s(state, plqc_pkg::PLQC_QUIET);
		chk_v(st, 4'h8);
		step(3999);
		chk_s(state, plqc_pkg::PLQC_QUIET);
		step(1);
		chk_v(st, 4'hB);
		step(249);
		chk_s(state, plqc_pkg::PLQC_REFRESH);
		step(11);
		chk_s(state, plqc_pkg::PLQC_QUIET);
		lw = 1'b0;
		step(1);
		chk_s(state, plqc_pkg::PLQC_WAKE);
		chk_v(st, 4'h2);
		step(125);
		chk_s(state, plqc_pkg::PLQC_ACTIVE);
		lw = 1'b1;
		step(4501);
		chk_s(state, plqc_pkg::PLQC_REFRESH);
		lw = 1'b0;
		step(1);
		chk_s(state, plqc_pkg::PLQC_WAKE);
		step(125);
		chk_s(state, plqc_pkg::PLQC_ACTIVE);
		// Energy support drops while quiet, then a mid-run reset.
		tw = 1'b1;
		rw = 1'b1;
		lw = 1'b1;
		step(600);
		chk_s(state, plqc_pkg::PLQC_QUIET);
		chk_v(lane_en, lanes_exp(1'b1));
		chk_v({3'h0, rx_lp}, 4'h1);
		eee = 1'b0;
		step(2);
		chk_s(state, plqc_pkg::PLQC_WAKE);
		chk_v(lane_en, lanes_exp(1'b0));
		chk_v({3'h0, rx_lp}, 4'h0);
		eee = 1'b1;
		rst = 1'b1;
		step(2);
		chk_v(lane_en, `PLQC_LANE_EN_RST);
		chk_s(state, plqc_pkg::PLQC_ACTIVE);
		chk_v(st, 4'h2);
		rst = 1'b0;
		step(1);
		chk_v(lane_en, `PLQC_LANE_EN_RST);
		chk_s(state, plqc_pkg::PLQC_SLEEP);
		chk_v({3'h0, rx_lp}, 4'h1);
		step(1);
		chk_v(lane_en, lanes_exp(1'b1));
		final_report;
	end

	// A hang is cut short and counted.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		final_report;
	end
endmodule

`default_nettype wire
